// >>> design/cpu_addr_decoder.v
// CPU address map decoder with direct and register bank relocation
// What this block does
// (R1) Whole 64 Kbyte space decoded, one region each
// (R2) 0x0000-0x007F selects I/O registers
// (R3) 0x0F80-0x0FFF selects extended I/O registers
// (R4) Direct 0x0090-0x00FF reaches RAM unrelocated while the bank pointer is zero
// (R5) Large part: direct reach up to 0x047F
// (R6) Small part: direct reach ends at 0x028F
// (R7) 0x0100-0x01FF general registers, also plain RAM
// (R8) 0xFFC0-0xFFFF selects vector table
// (R9) 0xFFBB-0xFFBF selects non-volatile register data
// (R10) Direct 0x0000-0x007F ignores bank pointer
// (R11) Bank pointer resets to zero, identity map
// (R12) Pointer 1..7 maps to 128-byte windows
// (R13) Exactly one select while CPU_REQ_I is high, none without a request, combinational, same cycle
`timescale 1ns/100ps
`include "addr_map_defines.vh"
module cpu_addr_decoder #(
	parameter SMALL_RAM = 0,
	parameter [`ADDR_W-1:0] FLASH_LO = `FLASH_LO_DEFAULT
) (
	input  wire                    SYS_CLK_I,
	input  wire                    RESET_I,
	input  wire                    CPU_REQ_I,
	input  wire                    CPU_WR_I,
	input  wire [1:0]              CPU_MODE_I,
	input  wire [`ADDR_W-1:0]      CPU_ADDR_I,
	input  wire [7:0]              CPU_OPERAND_I,
	input  wire [2:0]              CPU_REG_NUM_I,
	input  wire [7:0]              CPU_WDATA_I,
	output wire [`ADDR_W-1:0]      EFF_ADDR_O,
	output wire                    SEL_IO_O,
	output wire                    SEL_XIO_O,
	output wire                    SEL_RAM_O,
	output wire                    SEL_NVR_O,
	output wire                    SEL_VEC_O,
	output wire                    SEL_FLASH_O,
	output wire                    SEL_NONE_O,
	output wire                    GPR_HIT_O,
	output wire                    DIR_OVER_O,
	output reg  [7:0]              MIRROR_RDATA_O,
	output reg  [`REGION_W-1:0]    LAST_REGION_O,
	output reg  [`BANK_PTR_W-1:0]  BANK_PTR_O
);
	localparam [`ADDR_W-1:0] RAM_END = SMALL_RAM ? `RAM_END_SMALL : `RAM_END_LARGE;

	reg  [`BANK_PTR_W-1:0] direct_bank_pointer_q;
	reg  [`BANK_PTR_W-1:0] direct_bank_pointer_d;
	reg  [`REG_PTR_W-1:0]  reg_ptr_q;
	reg  [`REG_PTR_W-1:0]  reg_ptr_d;
	reg  [`ADDR_W-1:0]     eff_addr;
	wire [`ADDR_W-1:0]     dir_addr;
	wire [`ADDR_W-1:0]     gpr_addr;
	wire [`REGION_W-1:0]   region;
	wire                   dir_over;
	wire                   mirror_wr;

	dir_translate u_dir (
		.operand_i             (CPU_OPERAND_I),
		.direct_bank_pointer_i (direct_bank_pointer_q),
		.ram_end_i             (RAM_END),
		.addr_o                (dir_addr),
		.over_o                (dir_over)
	);

	// Eight registers per bank, 32 banks span the general register area
	assign gpr_addr = `GPR_LO + {8'h00, reg_ptr_q, 3'h0} + {13'h0000, CPU_REG_NUM_I}; // [R7]

	always @* begin
		case (CPU_MODE_I)
			`MODE_DIRECT: eff_addr = dir_addr;
			`MODE_GPR:    eff_addr = gpr_addr; // [R7]
			default:      eff_addr = CPU_ADDR_I; // [R1]
		endcase
	end

	region_decode u_region (
		.addr_i     (eff_addr),
		.ram_end_i  (RAM_END),
		.flash_lo_i (FLASH_LO),
		.region_o   (region)
	);

	// Selects stay combinational so the access completes this cycle
	assign EFF_ADDR_O  = eff_addr;
	assign SEL_IO_O    = CPU_REQ_I && (region == `REGION_IO); // [R13]
	assign SEL_XIO_O   = CPU_REQ_I && (region == `REGION_XIO); // [R13]
	assign SEL_RAM_O   = CPU_REQ_I && (region == `REGION_RAM); // [R13]
	assign SEL_NVR_O   = CPU_REQ_I && (region == `REGION_NVR); // [R13]
	assign SEL_VEC_O   = CPU_REQ_I && (region == `REGION_VEC); // [R13]
	assign SEL_FLASH_O = CPU_REQ_I && (region == `REGION_FLASH); // [R13]
	assign SEL_NONE_O  = CPU_REQ_I && (region == `REGION_NONE); // [R13]
	assign GPR_HIT_O   = CPU_REQ_I && (eff_addr >= `GPR_LO) && (eff_addr <= `GPR_HI); // [R7]
	assign DIR_OVER_O  = CPU_REQ_I && (CPU_MODE_I == `MODE_DIRECT) && dir_over; // [R6]

	// Pointers are written through their mirror byte in the I/O area
	assign mirror_wr = CPU_REQ_I && CPU_WR_I && (eff_addr == `MIRROR_ADDR);

	always @* begin
		direct_bank_pointer_d = direct_bank_pointer_q;
		reg_ptr_d = reg_ptr_q;
		if (mirror_wr) begin
			direct_bank_pointer_d = CPU_WDATA_I[2:0];
			reg_ptr_d = CPU_WDATA_I[7:3];
		end
	end

	always @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			direct_bank_pointer_q <= `BANK_PTR_RESET; // [R11]
			reg_ptr_q <= `REG_PTR_RESET;
			MIRROR_RDATA_O <= 8'h00;
			LAST_REGION_O <= `REGION_NONE;
			BANK_PTR_O <= `BANK_PTR_RESET;
		end else begin
			direct_bank_pointer_q <= direct_bank_pointer_d;
			reg_ptr_q <= reg_ptr_d;
			MIRROR_RDATA_O <= {reg_ptr_d, direct_bank_pointer_d};
			BANK_PTR_O <= direct_bank_pointer_d;
			if (CPU_REQ_I) begin
				LAST_REGION_O <= region;
			end
		end
	end
endmodule // cpu_addr_decoder

// >>> design/dir_translate.v
// Direct addressing operand relocation through the direct bank pointer
`timescale 1ns/100ps
`include "addr_map_defines.vh"
module dir_translate (
	input  wire [7:0]               operand_i,
	input  wire [`BANK_PTR_W-1:0]   direct_bank_pointer_i,
	input  wire [`ADDR_W-1:0]       ram_end_i,
	output reg  [`ADDR_W-1:0]       addr_o,
	output wire                     over_o
);
	always @* begin
		if (!operand_i[7]) begin
			addr_o = {8'h00, operand_i}; // [R10]
		end else if (direct_bank_pointer_i == `BANK_PTR_RESET) begin
			addr_o = {8'h00, operand_i}; // [R11] [R4]
		end else begin
			// Window base is pointer times 128 plus 128
			addr_o = {6'h00, direct_bank_pointer_i, 7'h00} + `BANK_BASE
				+ {9'h000, operand_i[6:0]}; // [R12]
		end
	end

	// Window 4 above its first 16 bytes and all of windows 5 to 7 lie past RAM on the small part
	assign over_o = (addr_o > ram_end_i); // [R5] [R6]
endmodule // dir_translate

// >>> design/region_decode.v
// Three-bit encoded region classification of a 16-bit address
`timescale 1ns/100ps
`include "addr_map_defines.vh"
module region_decode (
	input  wire [`ADDR_W-1:0]   addr_i,
	input  wire [`ADDR_W-1:0]   ram_end_i,
	input  wire [`ADDR_W-1:0]   flash_lo_i,
	output reg  [`REGION_W-1:0] region_o
);
	function in_range;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] lo;
		input [`ADDR_W-1:0] hi;
		begin
			in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	// Priority order keeps exactly one region even with odd parameters
	always @* begin
		if (in_range(addr_i, `IO_LO, `IO_HI)) begin
			region_o = `REGION_IO; // [R2]
		end else if (in_range(addr_i, `XIO_LO, `XIO_HI)) begin
			region_o = `REGION_XIO; // [R3]
		end else if (in_range(addr_i, `RAM_LO, ram_end_i)) begin
			region_o = `REGION_RAM; // [R4] [R7]
		end else if (in_range(addr_i, `VEC_LO, `VEC_HI)) begin
			region_o = `REGION_VEC; // [R8]
		end else if (in_range(addr_i, `NVR_LO, `NVR_HI)) begin
			region_o = `REGION_NVR; // [R9]
		end else if (in_range(addr_i, flash_lo_i, `NVR_LO - 16'h0001)) begin
			region_o = `REGION_FLASH;
		end else begin
			region_o = `REGION_NONE; // [R1]
		end
	end
endmodule // region_decode

// >>> pkg/addr_map_defines.vh
// Address map constants for the CPU region decoder
`ifndef ADDR_MAP_DEFINES_VH
`define ADDR_MAP_DEFINES_VH

`define ADDR_W            16
`define SPACE_TOP         16'hFFFF
`define IO_LO             16'h0000
`define IO_HI             16'h007F
`define XIO_LO            16'h0F80
`define XIO_HI            16'h0FFF
`define RAM_LO            16'h0090
`define DIR_NOBANK_HI     16'h00FF
`define RAM_END_LARGE     16'h047F
`define RAM_END_SMALL     16'h028F
`define GPR_LO            16'h0100
`define GPR_HI            16'h01FF
`define NVR_LO            16'hFFBB
`define NVR_HI            16'hFFBF
`define VEC_LO            16'hFFC0
`define VEC_HI            16'hFFFF
`define FLASH_LO_DEFAULT  16'h8000
`define BANK_BASE         16'h0080
`define BANK_PTR_W        3
`define BANK_PTR_RESET    3'h0
`define REG_PTR_W         5
`define REG_PTR_RESET     5'h00
`define MIRROR_ADDR       16'h0078
`define MODE_PLAIN        2'h0
`define MODE_DIRECT       2'h1
`define MODE_GPR          2'h2
`define REGION_W          3
`define REGION_NONE       3'h0
`define REGION_IO         3'h1
`define REGION_XIO        3'h2
`define REGION_RAM        3'h3
`define REGION_NVR        3'h4
`define REGION_VEC        3'h5
`define REGION_FLASH      3'h6

`endif

// >>> testbench/cpu_addr_decoder_chk.sv
// Assertion checker for the CPU address decoder
`timescale 1ns/100ps
`include "addr_map_defines.vh"
module cpu_addr_decoder_chk #(
	parameter SMALL_RAM = 0
) (
	input wire                SYS_CLK_I,
	input wire                RESET_I,
	input wire                CPU_REQ_I,
	input wire                CPU_WR_I,
	input wire [1:0]          CPU_MODE_I,
	input wire [7:0]          CPU_OPERAND_I,
	input wire [7:0]          CPU_WDATA_I,
	input wire [`ADDR_W-1:0]  EFF_ADDR_O,
	input wire                SEL_IO_O,
	input wire                SEL_XIO_O,
	input wire                SEL_RAM_O,
	input wire                SEL_NVR_O,
	input wire                SEL_VEC_O,
	input wire                SEL_FLASH_O,
	input wire                SEL_NONE_O,
	input wire                GPR_HIT_O,
	input wire [7:0]          MIRROR_RDATA_O,
	input wire [2:0]          BANK_PTR_O
);
	localparam [15:0] RAM_END = SMALL_RAM ? `RAM_END_SMALL : `RAM_END_LARGE;
	wire       rq = CPU_REQ_I;
	wire [6:0] sel = {SEL_IO_O, SEL_XIO_O, SEL_RAM_O, SEL_NVR_O, SEL_VEC_O, SEL_FLASH_O, SEL_NONE_O};
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);
	one_select_a: assert property (rq |-> $onehot(sel)) else $error("select not one-hot");
	io_select_a: assert property (rq && EFF_ADDR_O <= 16'h007F |-> SEL_IO_O) else $error("io");
	xio_select_a: assert property (rq && EFF_ADDR_O >= 16'h0F80 && EFF_ADDR_O <= 16'h0FFF
		|-> SEL_XIO_O) else $error("xio");
	ram_select_a: assert property (rq && EFF_ADDR_O >= 16'h0090 && EFF_ADDR_O <= RAM_END
		|-> SEL_RAM_O) else $error("ram");
	nvr_select_a: assert property (rq && EFF_ADDR_O >= 16'hFFBB && EFF_ADDR_O <= 16'hFFBF
		|-> SEL_NVR_O) else $error("nvr");
	vec_select_a: assert property (rq && EFF_ADDR_O >= 16'hFFC0 |-> SEL_VEC_O) else $error("vec");
	gpr_hit_a: assert property (rq |-> GPR_HIT_O == (EFF_ADDR_O[15:8] == 8'h01))
		else $error("gpr hit");
	dir_fixed_a: assert property (rq && CPU_MODE_I == 2'h1 && !CPU_OPERAND_I[7]
		|-> EFF_ADDR_O == {8'h00, CPU_OPERAND_I}) else $error("direct low");
	dir_bank_a: assert property (rq && CPU_MODE_I == 2'h1 && CPU_OPERAND_I[7]
		&& BANK_PTR_O != 3'h0
		|-> EFF_ADDR_O == {6'h00, BANK_PTR_O, 7'h00} + {9'h001, CPU_OPERAND_I[6:0]})
		else $error("direct bank");
	ptr_write_a: assert property (rq && CPU_WR_I && EFF_ADDR_O == 16'h0078
		|=> BANK_PTR_O == $past(CPU_WDATA_I[2:0])) else $error("pointer write");
	ptr_reset_a: assert property (disable iff (1'b0) RESET_I |=> BANK_PTR_O == 3'h0
		&& MIRROR_RDATA_O == 8'h00) else $error("pointer reset");
	cover property (rq && SEL_NVR_O);
	cover property (rq && CPU_MODE_I == 2'h1 && BANK_PTR_O == 3'h7);
	cover property (rq && SEL_NONE_O);
endmodule // cpu_addr_decoder_chk
bind cpu_addr_decoder cpu_addr_decoder_chk #(.SMALL_RAM(SMALL_RAM)) chk (.*);

// >>> testbench/cpu_addr_decoder_tb_top.sv
// Self-checking bench for the CPU address decoder
`timescale 1ns/100ps
module cpu_addr_decoder_tb_top;
	reg         clk = 0;
	reg         rst = 1;
	integer     bad_count = 0;
	integer     checked = 0;
	integer     cyc = 0;
	integer     p;
	wire        req, wr;
	wire [1:0]  mode;
	wire [15:0] addr, eff;
	wire [7:0]  op, wd, mir;
	wire [2:0]  rn, bp, last;
	wire [6:0]  sel;
	wire        gpr;
	wire        over, over_s;
	wire [6:0]  sel_s;
	cpu_core_model m (.clk_i(clk), .req_o(req), .wr_o(wr), .mode_o(mode), .addr_o(addr),
		.operand_o(op), .reg_num_o(rn), .wdata_o(wd));
	cpu_addr_decoder dut (.SYS_CLK_I(clk), .RESET_I(rst), .CPU_REQ_I(req), .CPU_WR_I(wr),
		.CPU_MODE_I(mode), .CPU_ADDR_I(addr), .CPU_OPERAND_I(op), .CPU_REG_NUM_I(rn),
		.CPU_WDATA_I(wd), .EFF_ADDR_O(eff), .SEL_IO_O(sel[6]), .SEL_XIO_O(sel[5]),
		.SEL_RAM_O(sel[4]), .SEL_NVR_O(sel[3]), .SEL_VEC_O(sel[2]), .SEL_FLASH_O(sel[1]),
		.SEL_NONE_O(sel[0]), .GPR_HIT_O(gpr), .DIR_OVER_O(over), .MIRROR_RDATA_O(mir),
		.LAST_REGION_O(last), .BANK_PTR_O(bp));
	// Small RAM variant shares the stimulus to show where direct reach ends
	cpu_addr_decoder #(.SMALL_RAM(1)) dut_small (.SYS_CLK_I(clk), .RESET_I(rst),
		.CPU_REQ_I(req), .CPU_WR_I(wr), .CPU_MODE_I(mode), .CPU_ADDR_I(addr),
		.CPU_OPERAND_I(op), .CPU_REG_NUM_I(rn), .CPU_WDATA_I(wd), .EFF_ADDR_O(),
		.SEL_IO_O(sel_s[6]), .SEL_XIO_O(sel_s[5]), .SEL_RAM_O(sel_s[4]), .SEL_NVR_O(sel_s[3]),
		.SEL_VEC_O(sel_s[2]), .SEL_FLASH_O(sel_s[1]), .SEL_NONE_O(sel_s[0]), .GPR_HIT_O(),
		.DIR_OVER_O(over_s), .MIRROR_RDATA_O(), .LAST_REGION_O(), .BANK_PTR_O());
	initial forever #5 clk = ~clk;
	task chk(input [15:0] seen, input [15:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("BAD %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc > 1000) begin
			bad_count = bad_count + 1;
			summarize;
		end
	end
	// Plain accesses at region edges, except the RAM top and the flash low end
	task plain(input [15:0] a, input [6:0] s, input g);
		m.acc(2'h0, a, 8'h00, 1'b0, 8'h00);
		#1 chk({8'h00, gpr, sel}, {8'h00, g, s});
	endtask
	task t_plain;
		plain(16'h0000, 7'h40, 0); plain(16'h007F, 7'h40, 0);
		plain(16'h0F80, 7'h20, 0); plain(16'h0FFF, 7'h20, 0);
		plain(16'h0090, 7'h10, 0); plain(16'h01FF, 7'h10, 1);
		plain(16'hFFBB, 7'h08, 0); plain(16'hFFBF, 7'h08, 0);
		plain(16'hFFC0, 7'h04, 0); plain(16'hFFFF, 7'h04, 0);
		plain(16'hFFBA, 7'h02, 0); plain(16'h0080, 7'h01, 0);
		m.idle;
	endtask
	// Reset state: identity direct map and register bank access
	task t_reset;
		chk(bp, 3'h0); chk(mir, 8'h00);
		m.acc(2'h1, 16'h0000, 8'h95, 1'b0, 8'h00);
		#1 chk(eff, 16'h0095); chk(sel, 7'h10);
		m.acc(2'h2, 16'h0000, 8'h05, 1'b0, 8'h00);
		#1 chk({gpr, eff}, {1'b1, 16'h0105});
		m.idle;
		chk(last, 3'h3);
	endtask
	// Pointer values 1 to 7, window edges and the fixed low area
	task t_banks;
		for (p = 1; p < 8; p = p + 1) begin
			m.acc(2'h0, 16'h0078, 8'h00, 1'b1, p[7:0]);
			m.acc(2'h1, 16'h0000, 8'h80, 1'b0, 8'h00);
			#1 chk(bp, p[2:0]); chk(eff, 16'h0080 + p * 128);
			m.acc(2'h1, 16'h0000, 8'hFF, 1'b0, 8'h00);
			#1 chk(eff, 16'h00FF + p * 128); chk(sel, 7'h10);
			chk({over, over_s, sel_s}, {1'b0, p > 3, (p > 3) ? 7'h01 : 7'h10});
			m.acc(2'h1, 16'h0000, 8'h8F, 1'b0, 8'h00);
			#1 chk({over_s, sel_s}, {p > 4, (p > 4) ? 7'h01 : 7'h10});
			m.acc(2'h1, 16'h0000, 8'h10, 1'b0, 8'h00);
			#1 chk(eff, 16'h0010);
		end
		m.idle;
	endtask
	// Reset in mid-run after the pointer was left at its highest value
	task t_midreset;
		@(negedge clk);
		rst = 1;
		@(negedge clk);
		rst = 0;
		chk({last, bp}, 6'h00); chk(mir, 8'h00);
		m.acc(2'h1, 16'h0000, 8'h85, 1'b0, 8'h00);
		#1 chk(eff, 16'h0085); chk(sel, 7'h01);
		m.idle;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst = 0;
		t_reset;
		t_plain;
		t_banks;
		t_midreset;
		summarize;
	end
endmodule // cpu_addr_decoder_tb_top

// >>> testbench/cpu_core_model.sv
// CPU core model issuing plain, direct and register accesses
`timescale 1ns/100ps
module cpu_core_model (
	input  wire        clk_i,
	output reg         req_o,
	output reg         wr_o,
	output reg  [1:0]  mode_o,
	output reg  [15:0] addr_o,
	output reg  [7:0]  operand_o,
	output reg  [2:0]  reg_num_o,
	output reg  [7:0]  wdata_o
);
	initial {req_o, wr_o, mode_o, addr_o, operand_o, reg_num_o, wdata_o} = 0;
	// One access, driven on the falling edge and held a full cycle
	task acc(input [1:0] m, input [15:0] a, input [7:0] o, input w, input [7:0] d);
		@(negedge clk_i);
		{req_o, mode_o, addr_o, operand_o, wr_o, wdata_o} = {1'b1, m, a, o, w, d};
		reg_num_o = o[2:0];
	endtask
	// Released bus inverts address, operand and data; mode and register number keep the last value
	task idle;
		@(negedge clk_i);
		{req_o, wr_o} = 2'b00;
		{addr_o, operand_o, wdata_o} = ~{addr_o, operand_o, wdata_o};
	endtask
endmodule // cpu_core_model
